// ===== hw/trig_seq_cfg.svh
/*
 * Constants of the timing trigger sequencer: widths, reset values and the
 * internal-level cost steps (one to four) from which level_cost builds each macro kind's cost but MAC_NONE's, which is zero.
 * Assumes inclusion by its bare name from the package and the design.
 */
`ifndef TRIG_SEQ_CFG_SVH
`define TRIG_SEQ_CFG_SVH

`define TS_DATA_W      16
`define TS_CHAN_W      4
`define TS_CNT_W       16
`define TS_NUM_LEVELS  10
`define TS_LVL_POOL    10
`define TS_IDX_W       4
`define TS_POOL_W      5
`define TS_CNT_RST     16'h0000
`define TS_COST_ONE    5'h01
`define TS_COST_TWO    5'h02
`define TS_COST_THREE  5'h03
`define TS_COST_FOUR   5'h04

`endif

// ===== hw/trig_seq_pkg.sv
/*
 * Types of the timing trigger sequencer: macro kinds, edge kinds,
 * configuration operations and one stored level.
 * Assumes trig_seq_cfg.svh on the include path.
 */
`include "trig_seq_cfg.svh"

package trig_seq_pkg;

	typedef enum logic [3:0] {
		MAC_NONE, MAC_USER, MAC_ANY_N, MAC_LONG, MAC_SHORT, MAC_EDGE, MAC_EDGE_N,
		MAC_QUAL, MAC_EARLY, MAC_LATE, MAC_CLOSE, MAC_FAR, MAC_WIDTH, MAC_DELAY
	} macro_type;

	typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_EITHER} edge_type;

	typedef enum logic [2:0] {
		CFG_NOP, CFG_WRITE, CFG_INSERT, CFG_DELETE, CFG_CLEAR, CFG_BREAK, CFG_RESTORE
	} cfg_op_type;

	typedef struct packed {
		macro_type              macro;
		logic [`TS_DATA_W-1:0]  pat;
		logic [`TS_DATA_W-1:0]  care;
		logic                   absent;
		logic                   lt;
		logic [`TS_CHAN_W-1:0]  chan;
		edge_type               edge_sel;
		logic [`TS_CNT_W-1:0]   count;
		logic [`TS_CNT_W-1:0]   dur;
		logic [`TS_CNT_W-1:0]   dur2;
	} level_type;

endpackage

// ===== hw/timing_trigger_sequencer.sv
/*
 * Timing-mode trigger sequencer: an ordered table of sequence levels, each a
 * macro, evaluated once per sample clock against the probed channels.
 * Assumes probe data already synchronous to ref_clk_i, one sample per clock.
 */
`timescale 1ns/1ps
`include "trig_seq_cfg.svh"

module timing_trigger_sequencer #(
	parameter int NUM_LEVELS = `TS_NUM_LEVELS,
	parameter int LVL_POOL   = `TS_LVL_POOL
) (
	// clock and reset
	input  wire logic                           ref_clk_i,
	input  wire logic                           srst_i,
	// probed channels
	input  wire logic [`TS_DATA_W-1:0]          data_i,
	// acquisition control
	input  wire logic                           start_i,
	// configuration
	input  wire trig_seq_pkg::cfg_op_type       cfg_op_i,
	input  wire logic [`TS_IDX_W-1:0]           cfg_idx_i,
	input  wire trig_seq_pkg::macro_type        cfg_macro_i,
	input  wire logic [`TS_DATA_W-1:0]          cfg_pat_i,
	input  wire logic [`TS_DATA_W-1:0]          cfg_care_i,
	input  wire logic                           cfg_absent_i,
	input  wire logic                           cfg_lt_i,
	input  wire logic [`TS_CHAN_W-1:0]          cfg_chan_i,
	input  wire trig_seq_pkg::edge_type         cfg_edge_i,
	input  wire logic [`TS_CNT_W-1:0]           cfg_count_i,
	input  wire logic [`TS_CNT_W-1:0]           cfg_dur_i,
	input  wire logic [`TS_CNT_W-1:0]           cfg_dur2_i,
	// status
	output logic                                trigger_o,
	output logic                                armed_o,
	output logic [`TS_IDX_W-1:0]                level_o,
	output logic [`TS_POOL_W-1:0]               levels_free_o,
	output logic                                broken_o,
	output logic                                cfg_err_o
);
	import trig_seq_pkg::*;

	typedef struct packed {
		level_type [NUM_LEVELS-1:0] tbl;
		level_type [NUM_LEVELS-1:0] shadow;
		logic [`TS_IDX_W-1:0]       num;
		logic [`TS_IDX_W-1:0]       level;
		logic [`TS_CNT_W-1:0]       cnt;
		logic [`TS_CNT_W-1:0]       tmr;
		logic                       phase;
		logic [`TS_DATA_W-1:0]      first;
		logic [`TS_DATA_W-1:0]      prev;
		logic                       prev_cond;
		logic                       armed;
		logic                       trigger;
		logic                       broken;
		logic                       cfg_err;
		logic [`TS_POOL_W-1:0]      free;
	} state_type;

	localparam logic [`TS_CNT_W-1:0] CNT_MAX = {`TS_CNT_W{1'b1}};

	state_type state_ff;
	state_type nxt_state;

	function automatic logic [`TS_POOL_W-1:0] level_cost(input level_type l);
		logic [`TS_POOL_W-1:0] x;
		x = {{(`TS_POOL_W-1){1'b0}}, l.absent};
		unique case (l.macro)
			MAC_NONE:  level_cost = '0;
			MAC_USER:  level_cost = l.lt ? `TS_COST_FOUR + x : `TS_COST_ONE;
			MAC_SHORT, MAC_WIDTH: level_cost = `TS_COST_FOUR + x;
			MAC_EARLY, MAC_CLOSE: level_cost = `TS_COST_THREE + x;
			MAC_LATE, MAC_FAR:    level_cost = `TS_COST_TWO;
			default:   level_cost = `TS_COST_ONE;
		endcase
	endfunction

	function automatic logic [`TS_POOL_W+3:0] table_cost(input level_type [NUM_LEVELS-1:0] t);
		logic [`TS_POOL_W+3:0] sum;
		sum = '0;
		for (int j = 0; j < NUM_LEVELS; j++) begin
			sum = sum + {4'h0, level_cost(t[j])};
		end
		table_cost = sum;
	endfunction

	level_type             cur;
	level_type             new_lvl;
	level_type [NUM_LEVELS-1:0] cand;
	logic                  match;
	logic                  cond;
	logic                  cur_bit;
	logic                  prv_bit;
	logic                  edge_hit;
	logic                  hit;
	logic [`TS_CNT_W-1:0]  tinc;
	logic [`TS_CNT_W-1:0]  cinc;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.cfg_err = 1'b0;
		nxt_state.prev = data_i;
		cand = state_ff.tbl;
		cur = state_ff.tbl[state_ff.level];
		new_lvl = '{macro: cfg_macro_i, pat: cfg_pat_i, care: cfg_care_i,
			absent: cfg_absent_i, lt: cfg_lt_i, chan: cfg_chan_i, edge_sel: cfg_edge_i,
			count: cfg_count_i, dur: cfg_dur_i, dur2: cfg_dur2_i};
		hit = 1'b0;

		if (cfg_op_i != CFG_NOP && state_ff.armed) begin
			nxt_state.cfg_err = 1'b1;
		end else begin
			unique case (cfg_op_i)
				CFG_NOP: begin
				end
				CFG_WRITE: begin
					if (cfg_idx_i >= state_ff.num) begin
						nxt_state.cfg_err = 1'b1;
					end else begin
						cand[cfg_idx_i] = new_lvl;
					end
				end
				CFG_INSERT: begin
					if (cfg_idx_i > state_ff.num || 32'(state_ff.num) >= NUM_LEVELS) begin
						nxt_state.cfg_err = 1'b1;
					end else begin
						for (int j = NUM_LEVELS - 1; j > 0; j--) begin
							if (j > int'(cfg_idx_i)) begin
								cand[j] = state_ff.tbl[j-1];
							end
						end
						cand[cfg_idx_i] = new_lvl;
						nxt_state.num = state_ff.num + 1'b1;
					end
				end
				CFG_DELETE: begin
					if (cfg_idx_i >= state_ff.num) begin
						nxt_state.cfg_err = 1'b1;
					end else begin
						for (int j = 0; j < NUM_LEVELS - 1; j++) begin
							if (j >= int'(cfg_idx_i)) begin
								cand[j] = state_ff.tbl[j+1];
							end
						end
						cand[NUM_LEVELS-1] = '0;
						nxt_state.num = state_ff.num - 1'b1;
					end
				end
				CFG_CLEAR: begin
					cand = '0;
					nxt_state.num = '0;
					nxt_state.broken = 1'b0;
				end
				CFG_BREAK: begin
					if (state_ff.broken) begin
						nxt_state.cfg_err = 1'b1;
					end else begin
						nxt_state.shadow = state_ff.tbl;
						nxt_state.broken = 1'b1;
					end
				end
				CFG_RESTORE: begin
					if (!state_ff.broken) begin
						nxt_state.cfg_err = 1'b1;
					end else begin
						cand = state_ff.shadow;
						nxt_state.num = state_ff.num;
						nxt_state.broken = 1'b0;
					end
				end
				default: nxt_state.cfg_err = 1'b1;
			endcase
		end
		// pool check on every table change but a restore
		if (table_cost(cand) > (`TS_POOL_W+4)'(LVL_POOL) && cfg_op_i != CFG_RESTORE) begin
			nxt_state.cfg_err = 1'b1;
		end
		if (nxt_state.cfg_err) begin
			nxt_state.num = state_ff.num;
			nxt_state.broken = state_ff.broken;
			nxt_state.shadow = state_ff.shadow;
		end else begin
			nxt_state.tbl = cand;
			nxt_state.free = (`TS_POOL_W)'((`TS_POOL_W+4)'(LVL_POOL) - table_cost(cand));
		end

		match = ((data_i ^ cur.pat) & cur.care) == '0;
		cond = match ^ cur.absent;
		cur_bit = data_i[cur.chan];
		prv_bit = state_ff.prev[cur.chan];
		unique case (cur.edge_sel)
			EDGE_RISE: edge_hit = cur_bit & ~prv_bit;
			EDGE_FALL: edge_hit = ~cur_bit & prv_bit;
			default:   edge_hit = cur_bit ^ prv_bit;
		endcase
		tinc = (state_ff.tmr == CNT_MAX) ? state_ff.tmr : state_ff.tmr + 1'b1;
		cinc = state_ff.cnt + 1'b1;
		nxt_state.prev_cond = cond;

		if (state_ff.armed) begin
			unique case (cur.macro)
				MAC_USER: begin
					if (cur.lt) begin
						nxt_state.tmr = cond ? tinc : '0;
						hit = state_ff.prev_cond && !cond && state_ff.tmr < cur.dur;
					end else begin
						hit = cond;
					end
				end
				MAC_ANY_N: begin
					if (!state_ff.phase) begin
						nxt_state.first = data_i;
						nxt_state.phase = 1'b1;
						nxt_state.cnt = 16'h0001;
						hit = cur.count <= 16'h0001;
					end else if (data_i == state_ff.first) begin
						nxt_state.cnt = cinc;
						hit = cinc >= cur.count;
					end
				end
				MAC_LONG: begin
					nxt_state.tmr = cond ? tinc : '0;
					hit = cond && tinc >= cur.dur;
				end
				MAC_SHORT: begin
					nxt_state.tmr = cond ? tinc : '0;
					hit = state_ff.prev_cond && !cond && state_ff.tmr < cur.dur;
				end
				MAC_EDGE: hit = edge_hit;
				MAC_EDGE_N: begin
					if (edge_hit) begin
						nxt_state.cnt = cinc;
						hit = cinc >= cur.count;
					end
				end
				MAC_QUAL: hit = edge_hit && match;
				MAC_EARLY: begin
					if (!state_ff.phase) begin
						nxt_state.phase = edge_hit;
						nxt_state.tmr = '0;
					end else if (match && state_ff.tmr < cur.dur) begin
						hit = 1'b1;
					end else begin
						nxt_state.tmr = tinc;
						nxt_state.phase = tinc < cur.dur;
					end
				end
				MAC_LATE: begin
					if (!state_ff.phase) begin
						nxt_state.phase = edge_hit;
						nxt_state.tmr = '0;
					end else if (match) begin
						nxt_state.phase = 1'b0;
					end else begin
						nxt_state.tmr = tinc;
						hit = tinc >= cur.dur;
					end
				end
				MAC_CLOSE, MAC_FAR: begin
					nxt_state.tmr = tinc;
					if (edge_hit) begin
						nxt_state.phase = 1'b1;
						nxt_state.tmr = '0;
						if (state_ff.phase) begin
							hit = (cur.macro == MAC_CLOSE) ? (state_ff.tmr < cur.dur)
								: (state_ff.tmr >= cur.dur);
						end
					end
				end
				MAC_WIDTH: begin
					nxt_state.tmr = cond ? tinc : '0;
					hit = state_ff.prev_cond && !cond
						&& (state_ff.tmr < cur.dur || state_ff.tmr > cur.dur2);
				end
				MAC_DELAY: begin
					nxt_state.tmr = tinc;
					hit = tinc >= cur.dur;
				end
				default: hit = 1'b1;
			endcase
			if (hit) begin
				nxt_state.cnt = '0;
				nxt_state.tmr = '0;
				nxt_state.phase = 1'b0;
				nxt_state.prev_cond = 1'b0;
				if (state_ff.level + 1'b1 >= state_ff.num) begin
					nxt_state.trigger = 1'b1;
					nxt_state.armed = 1'b0;
				end else begin
					nxt_state.level = state_ff.level + 1'b1;
				end
			end
		end

		if (start_i) begin
			nxt_state.level = '0;
			nxt_state.cnt = `TS_CNT_RST;
			nxt_state.tmr = `TS_CNT_RST;
			nxt_state.phase = 1'b0;
			nxt_state.prev_cond = 1'b0;
			nxt_state.trigger = 1'b0;
			nxt_state.armed = state_ff.num != '0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_ff <= '0;
			state_ff.free <= (`TS_POOL_W)'(LVL_POOL);
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign trigger_o     = state_ff.trigger;
	assign armed_o       = state_ff.armed;
	assign level_o       = state_ff.level;
	assign levels_free_o = state_ff.free;
	assign broken_o      = state_ff.broken;
	assign cfg_err_o     = state_ff.cfg_err;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	property p_start_clear;
		start_i |=> level_o == '0 && !trigger_o && state_ff.tmr == '0 && state_ff.cnt == '0;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start did not clear");

	property p_trig_hold;
		trigger_o && !start_i |=> trigger_o && !armed_o;
	endproperty
	a_trig_hold: assert property (p_trig_hold) else $error("trigger dropped");

	property p_edge_adv;
		armed_o && !start_i && cur.macro == MAC_EDGE && edge_hit
			|=> trigger_o || level_o == $past(level_o) + 1'b1;
	endproperty
	a_edge_adv: assert property (p_edge_adv) else $error("edge did not advance");

	property p_qual;
		armed_o && !start_i && cur.macro == MAC_QUAL && !(edge_hit && match)
			|=> level_o == $past(level_o) && !$rose(trigger_o);
	endproperty
	a_qual: assert property (p_qual) else $error("qualified edge fired early");

	property p_delay;
		armed_o && !start_i && cur.macro == MAC_DELAY && tinc < cur.dur
			|=> level_o == $past(level_o) && !$rose(trigger_o);
	endproperty
	a_delay: assert property (p_delay) else $error("delay ended early");

	property p_pool;
		levels_free_o <= (`TS_POOL_W)'(LVL_POOL);
	endproperty
	a_pool: assert property (p_pool) else $error("pool overdrawn");

	property p_err_keeps;
		cfg_err_o |-> state_ff.tbl == $past(state_ff.tbl) && broken_o == $past(broken_o);
	endproperty
	a_err_keeps: assert property (p_err_keeps) else $error("refused edit changed table");

	sequence s_broken;
		broken_o ##1 broken_o && cfg_op_i == CFG_RESTORE && !armed_o;
	endsequence
	property p_restore;
		s_broken |=> !broken_o && state_ff.tbl == $past(state_ff.shadow);
	endproperty
	a_restore: assert property (p_restore) else $error("restore failed");

	property p_break;
		!broken_o && !armed_o && cfg_op_i == CFG_BREAK |=> broken_o
			&& state_ff.shadow == $past(state_ff.tbl);
	endproperty
	a_break: assert property (p_break) else $error("break down failed");

endmodule

// ===== verif/probe_pod_model.sv
/*
 * Probe pod model: the system under test as seen through the pods.
 * Assumes the bench commands the level; pods deliver it one clock late.
 */
`timescale 1ns/1ps
module probe_pod_model (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	// commanded level
	input  wire logic [15:0] level_i,
	// probed channels
	output logic      [15:0] data_o
);
	// registered so edges never line up with bench drive
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			data_o <= 16'h0000;
		end else begin
			data_o <= level_i;
		end
	end
endmodule

// ===== verif/testbench.sv
/*
 * Self-checking bench of the timing trigger sequencer.
 * Assumes the package and configuration header on the include path.
 */
`timescale 1ns/1ps
module testbench;
	import trig_seq_pkg::*;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic        start = 1'b0;
	cfg_op_type  op = CFG_NOP;
	logic [3:0]  idx = 4'h0;
	macro_type   mac = MAC_NONE;
	logic        absent = 1'b0;
	logic        lt = 1'b0;
	logic [15:0] cnt = 16'h0000;
	logic [15:0] lvl = 16'h0000;
	logic [15:0] data;
	logic [15:0] pat = 16'h0000;
	logic [15:0] care = 16'h0000;
	logic [3:0]  chan = 4'h0;
	edge_type    edg = EDGE_RISE;
	logic        trigger_o, armed_o, broken_o, cfg_err_o;
	logic [3:0]  level_o;
	logic [4:0]  levels_free_o;
	int          n_fail = 0;
	int          checks_done = 0;

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	probe_pod_model u_pod (.ref_clk_i(ref_clk), .srst_i(srst), .level_i(lvl), .data_o(data));

	timing_trigger_sequencer #(.NUM_LEVELS(10), .LVL_POOL(10)) u_dut (
		.ref_clk_i(ref_clk), .srst_i(srst), .data_i(data), .start_i(start),
		.cfg_op_i(op), .cfg_idx_i(idx), .cfg_macro_i(mac), .cfg_pat_i(pat),
		.cfg_care_i(care), .cfg_absent_i(absent), .cfg_lt_i(lt), .cfg_chan_i(chan),
		.cfg_edge_i(edg), .cfg_count_i(cnt), .cfg_dur_i(cnt), .cfg_dur2_i(cnt),
		.trigger_o(trigger_o), .armed_o(armed_o), .level_o(level_o),
		.levels_free_o(levels_free_o), .broken_o(broken_o), .cfg_err_o(cfg_err_o));

	task automatic wrap_up;
		$display("checks=%0d fails=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cfg(input cfg_op_type o, input logic [3:0] i, input macro_type m,
		input logic a, input logic l, input logic [15:0] n);
		@(posedge ref_clk);
		op <= o;
		idx <= i;
		mac <= m;
		absent <= a;
		lt <= l;
		cnt <= n;
		@(posedge ref_clk);
		op <= CFG_NOP;
		#1;
	endtask

	task automatic go;
		@(posedge ref_clk);
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		#1;
	endtask

	task automatic pulse;
		@(posedge ref_clk);
		lvl <= 16'h0001;
		@(posedge ref_clk);
		lvl <= 16'h0000;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	// pod adds one clock: the design sees v for k samples
	task automatic hold(input logic [15:0] v, input int k);
		@(posedge ref_clk);
		lvl <= v;
		repeat (k - 1) @(posedge ref_clk);
		#1;
	endtask

	task automatic arm(input macro_type m, input logic [15:0] p, input logic [15:0] c,
		input logic [15:0] n);
		@(posedge ref_clk);
		pat <= p;
		care <= c;
		cfg(CFG_CLEAR, 4'h0, MAC_NONE, 1'b0, 1'b0, 16'h0000);
		cfg(CFG_INSERT, 4'h0, m, 1'b0, 1'b0, n);
		go();
	endtask

	task automatic t_user_any;
		arm(MAC_USER, 16'h0001, 16'h0001, 16'h0001);
		hold(16'h0000, 3);
		chk(trigger_o, 0);
		hold(16'h0001, 2);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		arm(MAC_ANY_N, 16'h0000, 16'h0000, 16'h0003);
		hold(16'h0001, 6);
		chk(trigger_o, 0);
		hold(16'h0000, 4);
		chk(trigger_o, 1);
		$display("user and any-state done");
	endtask

	task automatic t_durations;
		arm(MAC_LONG, 16'h0001, 16'h0001, 16'h0004);
		hold(16'h0001, 3);
		hold(16'h0000, 2);
		chk(trigger_o, 0);
		hold(16'h0001, 5);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		arm(MAC_SHORT, 16'h0001, 16'h0001, 16'h0004);
		hold(16'h0001, 5);
		hold(16'h0000, 3);
		chk(trigger_o, 0);
		hold(16'h0001, 2);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		arm(MAC_WIDTH, 16'h0001, 16'h0001, 16'h0003);
		hold(16'h0001, 3);
		hold(16'h0000, 3);
		chk(trigger_o, 0);
		hold(16'h0001, 5);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		$display("durations done");
	endtask

	task automatic t_pattern_edge;
		arm(MAC_QUAL, 16'h0003, 16'h0003, 16'h0001);
		hold(16'h0001, 3);
		hold(16'h0000, 3);
		hold(16'h0002, 3);
		hold(16'h0000, 3);
		chk(trigger_o, 0);
		hold(16'h0003, 3);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		arm(MAC_EARLY, 16'h0002, 16'h0002, 16'h0004);
		hold(16'h0001, 8);
		hold(16'h0003, 3);
		hold(16'h0000, 3);
		chk(trigger_o, 0);
		hold(16'h0001, 1);
		hold(16'h0003, 3);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		arm(MAC_LATE, 16'h0002, 16'h0002, 16'h0003);
		hold(16'h0001, 2);
		hold(16'h0003, 3);
		hold(16'h0000, 3);
		chk(trigger_o, 0);
		hold(16'h0001, 5);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		$display("pattern and edge done");
	endtask

	task automatic t_edge_pairs;
		arm(MAC_CLOSE, 16'h0000, 16'h0000, 16'h0004);
		hold(16'h0001, 2);
		hold(16'h0000, 6);
		hold(16'h0001, 2);
		hold(16'h0000, 3);
		chk(trigger_o, 0);
		hold(16'h0001, 1);
		hold(16'h0000, 1);
		hold(16'h0001, 2);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		arm(MAC_FAR, 16'h0000, 16'h0000, 16'h0004);
		hold(16'h0001, 1);
		hold(16'h0000, 1);
		hold(16'h0001, 2);
		hold(16'h0000, 3);
		chk(trigger_o, 0);
		hold(16'h0000, 4);
		hold(16'h0001, 2);
		hold(16'h0000, 3);
		chk(trigger_o, 1);
		$display("edge pairs done");
	endtask

	function automatic int cost_of(int m, int a, int l);
		case (m)
			4, 12: return 4 + a;
			8, 10: return 3 + a;
			9, 11: return 2;
			1: return l ? 4 + a : 1;
			default: return 1;
		endcase
	endfunction

	task automatic t_costs;
		for (int m = 1; m < 14; m++) begin
			for (int a = 0; a < 2; a++) begin
				for (int l = 0; l < 2; l++) begin
					cfg(CFG_INSERT, 4'h0, macro_type'(m[3:0]), a[0], l[0], 16'h0004);
					chk(levels_free_o, 10 - cost_of(m, a, l));
					cfg(CFG_CLEAR, 4'h0, MAC_NONE, 1'b0, 1'b0, 16'h0000);
					chk(levels_free_o, 10);
				end
			end
		end
		$display("costs done");
	endtask

	task automatic t_break;
		cfg(CFG_INSERT, 4'h0, MAC_EDGE, 1'b0, 1'b0, 16'h0001);
		cfg(CFG_WRITE, 4'h5, MAC_LONG, 1'b0, 1'b0, 16'h0001);
		chk(cfg_err_o, 1);
		cfg(CFG_RESTORE, 4'h0, MAC_NONE, 1'b0, 1'b0, 16'h0000);
		chk(cfg_err_o, 1);
		cfg(CFG_BREAK, 4'h0, MAC_NONE, 1'b0, 1'b0, 16'h0000);
		chk(broken_o, 1);
		cfg(CFG_WRITE, 4'h0, MAC_SHORT, 1'b0, 1'b0, 16'h0004);
		chk(levels_free_o, 6);
		cfg(CFG_RESTORE, 4'h0, MAC_NONE, 1'b0, 1'b0, 16'h0000);
		chk(broken_o, 0);
		chk(levels_free_o, 9);
		cfg(CFG_DELETE, 4'h0, MAC_NONE, 1'b0, 1'b0, 16'h0000);
		chk(levels_free_o, 10);
		$display("break done");
	endtask

	task automatic t_edges;
		cfg(CFG_INSERT, 4'h0, MAC_EDGE, 1'b0, 1'b0, 16'h0001);
		go();
		chk(armed_o, 1);
		repeat (3) @(posedge ref_clk);
		chk(trigger_o, 0);
		pulse();
		chk(trigger_o, 1);
		chk(armed_o, 0);
		cfg(CFG_WRITE, 4'h0, MAC_EDGE_N, 1'b0, 1'b0, 16'h0003);
		go();
		pulse();
		pulse();
		chk(trigger_o, 0);
		pulse();
		chk(trigger_o, 1);
		$display("edges done");
	endtask

	task automatic t_levels;
		cfg(CFG_WRITE, 4'h0, MAC_EDGE, 1'b0, 1'b0, 16'h0001);
		cfg(CFG_INSERT, 4'h1, MAC_EDGE, 1'b0, 1'b0, 16'h0001);
		go();
		pulse();
		chk(level_o, 1);
		cfg(CFG_INSERT, 4'h0, MAC_EDGE, 1'b0, 1'b0, 16'h0001);
		chk(cfg_err_o, 1);
		go();
		chk(level_o, 0);
		pulse();
		chk(trigger_o, 0);
		pulse();
		chk(trigger_o, 1);
		$display("levels done");
	endtask

	task automatic t_delay;
		int n;
		cfg(CFG_CLEAR, 4'h0, MAC_NONE, 1'b0, 1'b0, 16'h0000);
		cfg(CFG_INSERT, 4'h0, MAC_DELAY, 1'b0, 1'b0, 16'h0005);
		go();
		n = 0;
		while (trigger_o !== 1'b1) begin
			@(posedge ref_clk);
			#1;
			n++;
			if (n > 50) begin
				chk(trigger_o, 1);
				wrap_up();
			end
		end
		chk(n, 5);
		go();
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		#1;
		chk(armed_o, 0);
		chk(levels_free_o, 10);
		$display("delay done");
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		#1;
		chk(levels_free_o, 10);
		chk({trigger_o, armed_o, level_o, broken_o}, 0);
		t_costs();
		t_break();
		t_edges();
		t_levels();
		t_user_any();
		t_durations();
		t_pattern_edge();
		t_edge_pairs();
		t_delay();
		wrap_up();
	end
endmodule
